// file: hw/tmsc_consts.svh
// Purpose: constants of the timer master/slave trigger control block
// Assumes: apb byte addresses, 16-bit registers in the low half of the word
// Notes:   included by the top module and the bench
`ifndef TMSC_CONSTS_SVH
`define TMSC_CONSTS_SVH
`define TMSC_ADDR_W          12
`define TMSC_OFS_CTRL_TWO    12'h004
`define TMSC_OFS_SLAVE_MODE  12'h008
`define TMSC_REG_W           16
`define TMSC_RST_CTRL_TWO    16'h0000
`define TMSC_RST_SLAVE_MODE  16'h0000
`define TMSC_MASK_CTRL_TWO   16'h00F8
`define TMSC_MASK_SLAVE_MODE 16'h007F
`define TMSC_CCDMA_BIT       3
`define TMSC_MOSEL_LSB       4
`define TMSC_MOSEL_MSB       6
`define TMSC_XORSEL_BIT      7
`define TMSC_SFSEL_LSB       0
`define TMSC_SFSEL_MSB       2
`define TMSC_REFCLR_BIT      3
`define TMSC_TSRC_LSB        4
`define TMSC_TSRC_MSB        6
`endif

// file: hw/tmsc_pkg.sv
// Purpose: types of the timer master/slave trigger control block
// Assumes: field codes as in the control registers
// Notes:   constants live in tmsc_consts.svh
package tmsc_pkg;
  typedef enum logic [2:0] {
    TMSC_MM_RESET, TMSC_MM_ENABLE, TMSC_MM_UPDATE, TMSC_MM_CCPULSE,
    TMSC_MM_REF1, TMSC_MM_REF2, TMSC_MM_REF4, TMSC_MM_NONE
  } tmsc_master_sel_t;
  typedef enum logic [2:0] {
    TMSC_SM_OFF, TMSC_SM_ENC1, TMSC_SM_ENC2, TMSC_SM_ENC3,
    TMSC_SM_RESET, TMSC_SM_GATED, TMSC_SM_TRIGGER, TMSC_SM_EXTCLK
  } tmsc_slave_fn_t;
  typedef logic [15:0] tmsc_reg_t;
endpackage : tmsc_pkg

// file: hw/tmsc_top.sv
// Purpose: master/slave trigger control of a general-purpose timer
// Assumes: single pclk domain, inputs synchronous to pclk, apb slave
// Notes:   counter core, filters and channels live outside this block
`timescale 1ns/1ns
`default_nettype none
`include "tmsc_consts.svh"

////////////////////////////////////////////////////////////////////////
// Functional notes
// - dma request per channel on its cc event, or on update if select set
// - master select 000 drives trigger output from counter reset
// - master select 001 drives trigger output from counter enable
// - master select 010 drives trigger output from update event
// - master select 011 drives trigger output high while any capture/compare flag is high
// - codes 100, 101, 110 follow channel 1, 2, 4 compare references
// - input one is channel one pin, or xor of pins 1..3 when select set
// - slave 000 disabled; counter clocked by internal clock when enabled
// - slave 001 counts input two edges, direction from input one level
// - slave 010 counts input one edges, direction from input two level
// - slave 011 counts edges of both inputs, direction from the other
// - slave 100 trigger rising edge resets counter and requests update
// - slave 101 counter runs while trigger high, stops while low, no reset
// - slave 110 trigger rising edge starts the counter
// - slave 111 trigger rising edges clock the counter
// - reference clear source select, 0 picks the dedicated clear input
// - trigger source: internal 0..3, edge detector, inputs 1/2, ext trigger
module tmsc_top (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`TMSC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output var  logic [31:0]             prdata,
  output var  logic                    pready,
  output var  logic                    pslverr,
  input  wire logic                    counter_reset,
  input  wire logic                    counter_run_bit,
  input  wire logic                    update_event,
  input  wire logic [3:0]              cc_event,
  input  wire logic [3:0]              capture_compare_flag,
  input  wire logic                    chan1_compare_reference,
  input  wire logic                    chan2_compare_reference,
  input  wire logic                    chan4_compare_reference,
  input  wire logic [2:0]              channel_pins,
  input  wire logic [3:0]              internal_trigger,
  input  wire logic                    chan1_edge_detect,
  input  wire logic                    filtered_input_one,
  input  wire logic                    filtered_input_two,
  input  wire logic                    filtered_external_trigger,
  input  wire logic                    reference_clear_input,
  output var  logic                    trigger_output,
  output var  logic [3:0]              ccdma_request,
  output var  logic                    timer_input_one,
  output var  logic                    reference_clear,
  output var  logic                    count_tick,
  output var  logic                    count_down,
  output var  logic                    count_run,
  output var  logic                    slave_counter_reset,
  output var  logic                    slave_update,
  output var  logic                    slave_start
);
  import tmsc_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // register state
  tmsc_reg_t   ctrl_two_q, ctrl_two_d;
  tmsc_reg_t   slave_mode_q, slave_mode_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic        access;
  logic        hit_two, hit_slave;

  function automatic tmsc_reg_t reg_read(input logic [`TMSC_ADDR_W-1:0] a,
                                         input tmsc_reg_t c2,
                                         input tmsc_reg_t sm);
    tmsc_reg_t r;
    r = '0;
    if (a == `TMSC_OFS_CTRL_TWO) begin
      r = c2 & `TMSC_MASK_CTRL_TWO;
    end else if (a == `TMSC_OFS_SLAVE_MODE) begin
      r = sm & `TMSC_MASK_SLAVE_MODE;
    end
    return r;
  endfunction : reg_read

  always_comb begin
    access       = psel && penable;
    hit_two      = paddr == `TMSC_OFS_CTRL_TWO;
    hit_slave    = paddr == `TMSC_OFS_SLAVE_MODE;
    pready_d     = access && !pready_q;
    pslverr_d    = access && !pready_q && !hit_two && !hit_slave;
    prdata_d     = prdata_q;
    ctrl_two_d   = ctrl_two_q;
    slave_mode_d = slave_mode_q;
    if (access && !pready_q) begin
      prdata_d = pwrite ? 32'h0000_0000 : {16'h0000, reg_read(paddr, ctrl_two_q, slave_mode_q)};
    end
    if (access && pready_q && pwrite) begin
      if (hit_two) begin
        ctrl_two_d = pwdata[15:0] & `TMSC_MASK_CTRL_TWO;
      end
      if (hit_slave) begin
        slave_mode_d = pwdata[15:0] & `TMSC_MASK_SLAVE_MODE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_two_q   <= `TMSC_RST_CTRL_TWO;
      slave_mode_q <= `TMSC_RST_SLAVE_MODE;
      prdata_q     <= 32'h0000_0000;
      pready_q     <= 1'b0;
      pslverr_q    <= 1'b0;
    end else begin
      ctrl_two_q   <= ctrl_two_d;
      slave_mode_q <= slave_mode_d;
      prdata_q     <= prdata_d;
      pready_q     <= pready_d;
      pslverr_q    <= pslverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  //////////////////////////////////////////////////////////////////////
  // field decode
  tmsc_master_sel_t master_output_select;
  tmsc_slave_fn_t   slave_function_select;
  logic [2:0]       trigger_source_select;
  logic             trigger_input;

  always_comb begin
    master_output_select  = tmsc_master_sel_t'(ctrl_two_q[`TMSC_MOSEL_MSB:`TMSC_MOSEL_LSB]);
    slave_function_select = tmsc_slave_fn_t'(slave_mode_q[`TMSC_SFSEL_MSB:`TMSC_SFSEL_LSB]);
    trigger_source_select = slave_mode_q[`TMSC_TSRC_MSB:`TMSC_TSRC_LSB];
    unique case (trigger_source_select)
      3'h4:    trigger_input = chan1_edge_detect;
      3'h5:    trigger_input = filtered_input_one;
      3'h6:    trigger_input = filtered_input_two;
      3'h7:    trigger_input = filtered_external_trigger;
      default: trigger_input = internal_trigger[trigger_source_select[1:0]];
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // master side: trigger output, dma timing, input one, reference clear
  logic       tout_q, tout_d;
  logic [3:0] dma_q, dma_d;
  logic       in1x_q, in1x_d;
  logic       rclr_q, rclr_d;

  always_comb begin
    unique case (master_output_select)
      TMSC_MM_RESET:   tout_d = counter_reset;
      TMSC_MM_ENABLE:  tout_d = counter_run_bit;
      TMSC_MM_UPDATE:  tout_d = update_event;
      TMSC_MM_CCPULSE: tout_d = |capture_compare_flag;
      TMSC_MM_REF1:    tout_d = chan1_compare_reference;
      TMSC_MM_REF2:    tout_d = chan2_compare_reference;
      TMSC_MM_REF4:    tout_d = chan4_compare_reference;
      TMSC_MM_NONE:    tout_d = 1'b0;
    endcase
    dma_d  = ctrl_two_q[`TMSC_CCDMA_BIT] ? {4{update_event}} : cc_event;
    in1x_d = ctrl_two_q[`TMSC_XORSEL_BIT] ? ^channel_pins : channel_pins[0];
    rclr_d = slave_mode_q[`TMSC_REFCLR_BIT] ? filtered_external_trigger
                                            : reference_clear_input;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tout_q <= 1'b0;
      dma_q  <= 4'h0;
      in1x_q <= 1'b0;
      rclr_q <= 1'b0;
    end else begin
      tout_q <= tout_d;
      dma_q  <= dma_d;
      in1x_q <= in1x_d;
      rclr_q <= rclr_d;
    end
  end

  assign trigger_output  = tout_q;
  assign ccdma_request   = dma_q;
  assign timer_input_one = in1x_q;
  assign reference_clear = rclr_q;

  //////////////////////////////////////////////////////////////////////
  // slave side: counting source, direction, reset, gate, start
  logic prev_trg_q, prev_in1_q, prev_in2_q;
  logic tick_q, tick_d, down_q, down_d, run_q, run_d;
  logic sreset_q, sreset_d, supd_q, supd_d, start_q, start_d;
  logic trg_rise, e1, e2;

  always_comb begin
    trg_rise = trigger_input && !prev_trg_q;
    e1       = filtered_input_one ^ prev_in1_q;
    e2       = filtered_input_two ^ prev_in2_q;
    tick_d   = 1'b0;
    down_d   = down_q;
    run_d    = counter_run_bit;
    sreset_d = 1'b0;
    supd_d   = 1'b0;
    start_d  = 1'b0;
    unique case (slave_function_select)
      TMSC_SM_OFF: begin
        tick_d = counter_run_bit;
      end
      TMSC_SM_ENC1: begin
        tick_d = counter_run_bit && e2;
        down_d = e2 ? (filtered_input_one != filtered_input_two) : down_q;
      end
      TMSC_SM_ENC2: begin
        tick_d = counter_run_bit && e1;
        down_d = e1 ? (filtered_input_one == filtered_input_two) : down_q;
      end
      TMSC_SM_ENC3: begin
        tick_d = counter_run_bit && (e1 || e2);
        if (e1) begin
          down_d = filtered_input_one == filtered_input_two;
        end else if (e2) begin
          down_d = filtered_input_one != filtered_input_two;
        end
      end
      TMSC_SM_RESET: begin
        tick_d   = counter_run_bit;
        sreset_d = trg_rise;
        supd_d   = trg_rise;
      end
      TMSC_SM_GATED: begin
        run_d  = counter_run_bit && trigger_input;
        tick_d = counter_run_bit && trigger_input;
      end
      TMSC_SM_TRIGGER: begin
        start_d = trg_rise;
        tick_d  = counter_run_bit;
      end
      TMSC_SM_EXTCLK: begin
        tick_d = counter_run_bit && trg_rise;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_trg_q <= 1'b0;
      prev_in1_q <= 1'b0;
      prev_in2_q <= 1'b0;
      tick_q     <= 1'b0;
      down_q     <= 1'b0;
      run_q      <= 1'b0;
      sreset_q   <= 1'b0;
      supd_q     <= 1'b0;
      start_q    <= 1'b0;
    end else begin
      prev_trg_q <= trigger_input;
      prev_in1_q <= filtered_input_one;
      prev_in2_q <= filtered_input_two;
      tick_q     <= tick_d;
      down_q     <= down_d;
      run_q      <= run_d;
      sreset_q   <= sreset_d;
      supd_q     <= supd_d;
      start_q    <= start_d;
    end
  end

  assign count_tick          = tick_q;
  assign count_down          = down_q;
  assign count_run           = run_q;
  assign slave_counter_reset = sreset_q;
  assign slave_update        = supd_q;
  assign slave_start         = start_q;

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_dma_cc;
    (!ctrl_two_q[`TMSC_CCDMA_BIT] && cc_event[0]) |=> ccdma_request[0];
  endproperty
  a_dma_cc: assert property (p_dma_cc) else $error("cc dma request missing");

  property p_dma_upd;
    (ctrl_two_q[`TMSC_CCDMA_BIT] && !update_event) |=> ccdma_request == 4'h0;
  endproperty
  a_dma_upd: assert property (p_dma_upd) else $error("dma request without update");

  property p_trigger_output_reset;
    (master_output_select == TMSC_MM_RESET && counter_reset) |=> trigger_output;
  endproperty
  a_trigger_output_reset: assert property (p_trigger_output_reset) else $error("trigger output missed reset");

  property p_trigger_output_cc;
    (master_output_select == TMSC_MM_CCPULSE) ##1 (master_output_select == TMSC_MM_CCPULSE)
      |-> trigger_output == $past(|capture_compare_flag);
  endproperty
  a_trigger_output_cc: assert property (p_trigger_output_cc) else $error("trigger output not cc pulse");

  property p_in_one;
    !ctrl_two_q[`TMSC_XORSEL_BIT] |=> timer_input_one == $past(channel_pins[0]);
  endproperty
  a_in_one: assert property (p_in_one) else $error("input one not channel one pin");

  property p_reset_mode;
    (slave_function_select == TMSC_SM_RESET && trg_rise) |=> slave_counter_reset && slave_update;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("reset mode missed trigger edge");

  property p_gated;
    (slave_function_select == TMSC_SM_GATED && !trigger_input) |=> !count_run && !count_tick;
  endproperty
  a_gated: assert property (p_gated) else $error("gated counter ran while low");

  property p_extclk;
    (slave_function_select == TMSC_SM_EXTCLK && !trg_rise) |=> !count_tick;
  endproperty
  a_extclk: assert property (p_extclk) else $error("external clock tick without edge");

  property p_rsvd;
    pready |-> prdata[31:8] == 24'h000000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");

  c_write: cover property (psel && penable && pready && pwrite);
  c_trig:  cover property (slave_function_select == TMSC_SM_TRIGGER && slave_start);
  c_enc:   cover property (slave_function_select == TMSC_SM_ENC3 && count_tick);
endmodule : tmsc_top
`default_nettype wire

// file: bench/tmsc_casc_timer.sv
// Purpose: cascaded master timer that feeds the internal trigger lines
// Assumes: triggers are levels launched on pclk
// Notes:   only the selected line rises, the others stay low
`timescale 1ns/1ns
`default_nettype none
module tmsc_casc_timer (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] fire_sel,
  input  wire logic       fire,
  output var  logic [3:0] internal_trigger
);
  logic [3:0] trig_d;
  logic [3:0] trig_q;
  // one line per trigger source code 000..011
  always_comb begin
    trig_d = 4'h0;
    if (fire) begin
      trig_d[fire_sel] = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_q <= 4'h0;
    end else begin
      trig_q <= trig_d;
    end
  end
  assign internal_trigger = trig_q;
endmodule : tmsc_casc_timer
`default_nettype wire

// file: bench/test_tmsc_top.sv
// Purpose: self-checking bench of the trigger control block
// Assumes: inputs driven at rising edge except pins, rci and crun at falling edge, apb answer taken at rising edge, other outputs at falling edge
// Notes:   apb waits are bounded
`timescale 1ns/1ns
`default_nettype none
`include "tmsc_consts.svh"
module test_tmsc_top;
  import tmsc_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, crst = 0, crun = 0, upd = 0, r1 = 0, r2 = 0, r4 = 0, ced = 0;
  logic        fi1 = 0, fi2 = 0, fet = 0, rci = 0, fire = 0, trg, in1, rclr, tick, down, run, srst, supd, sst;
  logic [1:0]  fire_sel = 2'h0;
  logic [2:0]  pins = 3'h0;
  logic [3:0]  cce = 4'h0, ccf = 4'h0, itr, dma, acc;
  wire  [5:0]  obs = {run, tick, sst, supd, srst, trg};
  int          errors = 0, total_checks = 0, hits[6];
  int          em[8] = '{1, 1, 1, 2, 2, 3, 3, 3}, es[8] = '{6, 6, 5, 5, 6, 5, 6, 6};
  int          ev[8] = '{1, 0, 1, 0, 1, 1, 0, 1}, et[8] = '{1, 1, 0, 1, 0, 1, 1, 1};
  int          ed[8] = '{1, 0, 0, 1, 1, 1, 1, 0};
  always #25 pclk = ~pclk;
  tmsc_casc_timer i_tmsc_casc_timer (.pclk(pclk), .presetn(presetn), .fire_sel(fire_sel), .fire(fire),
    .internal_trigger(itr));
  tmsc_top i_tmsc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .counter_reset(crst), .counter_run_bit(crun), .update_event(upd), .cc_event(cce),
    .capture_compare_flag(ccf), .chan1_compare_reference(r1), .chan2_compare_reference(r2),
    .chan4_compare_reference(r4), .channel_pins(pins), .internal_trigger(itr), .chan1_edge_detect(ced),
    .filtered_input_one(fi1), .filtered_input_two(fi2), .filtered_external_trigger(fet),
    .reference_clear_input(rci), .trigger_output(trg), .ccdma_request(dma), .timer_input_one(in1),
    .reference_clear(rclr), .count_tick(tick), .count_down(down), .count_run(run),
    .slave_counter_reset(srst), .slave_update(supd), .slave_start(sst));
  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic ee);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk("prdata", exp, q);
    chk("pslverr", {31'h0, ee}, {31'h0, e});
  endtask : rd
  task automatic watch(input int n);
    for (int i = 0; i < 6; i++) hits[i] = 0;
    acc = 4'h0;
    repeat (n) begin
      @(negedge pclk);
      acc = acc | dma;
      for (int i = 0; i < 6; i++) if (obs[i] === 1'b1) hits[i]++;
    end
  endtask : watch
  task automatic set_src(input int t, input logic v);
    case (t)
      0, 1, 2, 3: begin fire_sel <= 2'(t); fire <= v; end
      4: ced <= v;
      5: fi1 <= v;
      6: fi2 <= v;
      default: fet <= v;
    endcase
  endtask : set_src
  task automatic drive_watch(input int t, input int len, input int n);
    // let outputs launched under the previous mode go by first
    @(posedge pclk);
    fork
      begin
        @(posedge pclk);
        set_src(t, 1'b1);
        repeat (len) @(posedge pclk);
        set_src(t, 1'b0);
      end
      watch(n);
    join
  endtask : drive_watch
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(`TMSC_OFS_CTRL_TWO, 32'h0, 1'b0);
    rd(`TMSC_OFS_SLAVE_MODE, 32'h0, 1'b0);
    rd(12'h00C, 32'h0, 1'b1);
    wr(`TMSC_OFS_CTRL_TWO, 32'hFFFF_FFFF);
    wr(`TMSC_OFS_SLAVE_MODE, 32'hFFFF_FF80);
    rd(`TMSC_OFS_CTRL_TWO, 32'h0000_00F8, 1'b0);
    rd(`TMSC_OFS_SLAVE_MODE, 32'h0, 1'b0);
    for (int m = 0; m < 8; m++) begin
      wr(`TMSC_OFS_CTRL_TWO, 32'(m) << 4);
      @(posedge pclk);
      {r4, r2, r1, ccf[0], upd, crun, crst} <= 7'h01 << m;
      @(posedge pclk);
      {r4, r2, r1, ccf[0], upd, crun, crst} <= 7'h00;
      watch(4);
      chk("trigger_output", (m < 7) ? 1 : 0, hits[0]);
    end
    for (int s = 0; s < 2; s++) begin
      wr(`TMSC_OFS_CTRL_TWO, 32'(s) << 3);
      @(posedge pclk);
      cce <= 4'h5;
      @(posedge pclk);
      cce <= 4'h0;
      watch(4);
      chk("ccdma_request cc", s ? 32'h0 : 32'h5, acc);
      drive_watch(7, 1, 5);
      @(posedge pclk);
      upd <= 1'b1;
      @(posedge pclk);
      upd <= 1'b0;
      watch(4);
      chk("ccdma_request update", s ? 32'hF : 32'h0, 32'(acc));
    end
    for (int p = 2; p < 4; p++) begin
      for (int s = 0; s < 2; s++) begin
        pins <= 3'(p);
        wr(`TMSC_OFS_CTRL_TWO, 32'(s) << 7);
        watch(3);
        chk("timer_input_one", s ? 32'(^3'(p)) : 32'(p & 1), 32'(in1));
      end
    end
    rci <= 1'b1;
    wr(`TMSC_OFS_SLAVE_MODE, 32'h0);
    watch(3);
    chk("reference_clear", 32'h1, 32'(rclr));
    wr(`TMSC_OFS_SLAVE_MODE, 32'h8);
    watch(3);
    chk("reference_clear", 32'h0, 32'(rclr));
    crun <= 1'b1;
    wr(`TMSC_OFS_SLAVE_MODE, 32'h0);
    watch(4);
    chk("count_tick", 32'h4, hits[4]);
    for (int t = 0; t < 8; t++) begin
      wr(`TMSC_OFS_SLAVE_MODE, 32'(t) << 4);
      wr(`TMSC_OFS_SLAVE_MODE, (32'(t) << 4) | 32'h4);
      drive_watch(t, 1, 7);
      chk("slave_counter_reset", 32'h1, hits[1]);
      chk("slave_update", 32'h1, hits[2]);
    end
    wr(`TMSC_OFS_SLAVE_MODE, 32'h76);
    drive_watch(7, 1, 7);
    chk("slave_start", 32'h1, hits[3]);
    wr(`TMSC_OFS_SLAVE_MODE, 32'h77);
    drive_watch(7, 3, 8);
    chk("count_tick", 32'h1, hits[4]);
    wr(`TMSC_OFS_SLAVE_MODE, 32'h75);
    drive_watch(7, 4, 8);
    chk("count_run", 32'h4, hits[5]);
    chk("slave_counter_reset", 32'h0, hits[1]);
    wr(`TMSC_OFS_SLAVE_MODE, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(`TMSC_OFS_SLAVE_MODE, 32'(em[i]));
      @(posedge pclk);
      set_src(es[i], 1'(ev[i]));
      watch(5);
      chk("count_tick", 32'(et[i]), hits[4]);
      chk("count_down", 32'(ed[i]), 32'(down));
    end
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`TMSC_OFS_CTRL_TWO, 32'h0, 1'b0);
    rd(`TMSC_OFS_SLAVE_MODE, 32'h0, 1'b0);
    tally_and_finish();
  end
endmodule : test_tmsc_top
`default_nettype wire
